// ===== src/pmirq_top.sv
/*
 * Protection monitor and interrupt logic of a buck controller: fault latches,
 * power-good timing, interrupt status and mask, switch and converter control.
 * Assumes a serial protocol engine in front presents decoded register
 * accesses, and analog comparators and the converter drive the sense inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module pmirq_top import pmirq_pkg::*; #(
    parameter int unsigned PG_QUAL_CYCLES = PG_QUAL_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic bus_sel,
    input wire logic [6:0] bus_dev_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_ack,
    input wire logic cmp_trip_a,
    input wire logic cmp_trip_b,
    input wire logic chip_en,
    input wire logic ov_cmp,
    input wire logic thermal_trip,
    input wire logic fb_in_inner,
    input wire logic fb_in_outer,
    input wire logic cycle_limit,
    input wire logic sw_cycle,
    input wire logic falling_output_cmp,
    input wire logic adc_done,
    input wire logic [6:0] adc_data,
    output logic [1:0] cmp_threshold_sel_a,
    output logic [1:0] cmp_threshold_sel_b,
    output logic outer_overcurrent_flag,
    output logic converter_suspend,
    output logic power_switches_off,
    output logic discharge_req,
    output logic power_ok,
    output logic [1:0] adc_mux_sel,
    output logic bulk_cap_switch_ctl,
    output logic pass_switch_drive_out,
    output logic pass_switch_drive_oe,
    output logic irq_pin_out,
    output logic irq_pin_oe
);
    // ********************************
    // input synchronisers
    // ********************************
    pmirq_sync_if #(.W(SYN_W)) sif ();
    assign sif.raw = {adc_done, falling_output_cmp, sw_cycle, cycle_limit, fb_in_outer,
                      fb_in_inner, thermal_trip, ov_cmp, chip_en, cmp_trip_b, cmp_trip_a};
    pmirq_sync #(.W(SYN_W)) u_sync (.ref_clk(ref_clk), .arst_n(arst_n), .sif(sif));

    logic [SYN_W-1:0] s;
    logic [SYN_W-1:0] s_q;
    assign s = sif.clean;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) s_q <= '0;
        else s_q <= s;
    end
    logic en;
    logic en_fall;
    logic en_rise;
    logic tick;
    assign en = s[I_EN];
    assign en_fall = s_q[I_EN] & ~en;
    assign en_rise = en & ~s_q[I_EN];
    assign tick = s[I_SW] & ~s_q[I_SW];

    // ********************************
    // register bus
    // ********************************
    logic [7:0] mask_r;
    logic [7:0] ctl_r;
    logic [7:0] out_r;
    logic [ADC_W-1:0] adc_r;
    logic [NSRC-1:0] stat_r;
    logic [7:0] stat_b;
    logic bus_hit;
    logic bus_we;
    logic stat_rd;
    assign bus_hit = bus_sel && (bus_dev_addr == DEV_ADDR);
    assign bus_we = bus_hit && bus_wr;
    assign stat_rd = bus_hit && bus_rd && (bus_addr == REG_STAT_A);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_r <= MASK_RST;
            ctl_r <= CTL_RST;
            out_r <= OUT_RST;
        end else if (bus_we) begin
            if (bus_addr == REG_MASK) mask_r <= bus_wdata;
            if (bus_addr == REG_CTL) ctl_r <= bus_wdata;
            if (bus_addr == REG_OUT) out_r <= bus_wdata;
        end
    end

    // unmapped addresses read zero and ignore writes
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= READ_ZERO;
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_hit && (bus_wr || bus_rd);
            bus_rdata <= READ_ZERO;
            if (bus_hit && bus_rd) begin
                unique case (bus_addr)
                    REG_MASK: bus_rdata <= mask_r;
                    REG_CTL: bus_rdata <= ctl_r;
                    REG_OUT: bus_rdata <= out_r;
                    REG_ADC: bus_rdata <= {1'b0, adc_r};
                    REG_STAT_A: bus_rdata <= {1'b0, stat_r};
                    REG_STAT_B: bus_rdata <= stat_b;
                    default: bus_rdata <= READ_ZERO;
                endcase
            end
        end
    end

    // ********************************
    // converter result and select
    // ********************************
    // data is taken once done has crossed, so it has long been stable
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) adc_r <= '0;
        else if (s[I_ADC] && !s_q[I_ADC]) adc_r <= adc_data;
    end
    assign adc_mux_sel = out_r[OUT_ADC_LSB +: 2];
    assign cmp_threshold_sel_a = ctl_r[CTL_THR_A_LSB +: 2];
    assign cmp_threshold_sel_b = ctl_r[CTL_THR_B_LSB +: 2];
    assign bulk_cap_switch_ctl = out_r[OUT_BULK];
    assign pass_switch_drive_out = 1'b0;
    assign pass_switch_drive_oe = out_r[OUT_PASS];
    assign irq_pin_out = 1'b0;

    // ********************************
    // outer current comparators
    // ********************************
    logic [EN_CNT_W-1:0] en_cnt_r;
    logic en_settled_r;
    logic outer_trip_r;
    logic trip_any;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_cnt_r <= '0;
            en_settled_r <= 1'b0;
        end else if (!en) begin
            en_cnt_r <= '0;
            en_settled_r <= 1'b0;
        end else if (!en_settled_r) begin
            en_cnt_r <= en_cnt_r + 1'b1;
            en_settled_r <= (en_cnt_r == EN_CNT_W'(EN_SETTLE_CYC - 1));
        end
    end

    assign trip_any = (s[I_CMP_A] & ~ctl_r[CTL_CMP_MASK_A]) |
                      (s[I_CMP_B] & ~ctl_r[CTL_CMP_MASK_B]);
    // restart mode drops the latch once the comparators fall back
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) outer_trip_r <= 1'b0;
        else if (trip_any && en_settled_r) outer_trip_r <= 1'b1;
        else if (!en || ctl_r[CTL_RESTART]) outer_trip_r <= 1'b0;
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) outer_overcurrent_flag <= 1'b0;
        else outer_overcurrent_flag <= outer_trip_r & en_settled_r;
    end

    // ********************************
    // over-voltage and inner over-current
    // ********************************
    logic ov_fault_r;
    logic inner_oc_r;
    logic [2:0] cl_cnt_r;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) ov_fault_r <= 1'b0;
        else if (s[I_OV]) ov_fault_r <= 1'b1;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cl_cnt_r <= '0;
            inner_oc_r <= 1'b0;
        end else if (!en) begin
            cl_cnt_r <= '0;
            inner_oc_r <= 1'b0;
        end else if (tick) begin
            if (!s[I_CLIM]) cl_cnt_r <= '0;
            else if (cl_cnt_r == OC_LIMIT_CYCLES) inner_oc_r <= 1'b1;
            else cl_cnt_r <= cl_cnt_r + 1'b1;
        end
    end

    // ********************************
    // thermal sequence
    // ********************************
    pmirq_therm_e th_r;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) th_r <= TH_RUN;
        else begin
            unique case (th_r)
                TH_RUN: if (s[I_THERM]) th_r <= TH_TRIP;
                TH_TRIP: if (!s[I_THERM]) th_r <= TH_DISCH;
                TH_DISCH: begin
                    if (s[I_THERM]) th_r <= TH_TRIP;
                    else if (!en) th_r <= TH_RUN;
                end
                default: th_r <= TH_TRIP;
            endcase
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_switches_off <= 1'b0;
            discharge_req <= 1'b0;
            converter_suspend <= 1'b0;
        end else begin
            power_switches_off <= ov_fault_r | inner_oc_r | (th_r != TH_RUN);
            discharge_req <= (th_r == TH_DISCH);
            converter_suspend <= outer_trip_r;
        end
    end

    // ********************************
    // power good
    // ********************************
    logic pg_mask;
    logic qual_run;
    logic qual_done;
    logic pg_r;
    logic pg_lost;
    logic startup_r;
    logic [1:0] out_cnt_r;
    assign pg_mask = out_r[OUT_PG_MASK];
    assign qual_run = en & s[I_FB_IN] & (th_r == TH_RUN);
    pmirq_qual_timer #(.CYCLES(PG_QUAL_CYCLES)) u_qual (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .run(qual_run),
        .done(qual_done)
    );

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) out_cnt_r <= '0;
        else if (s[I_FB_OUT] || !en) out_cnt_r <= '0;
        else if (tick && out_cnt_r != PG_OUT_CYCLES) out_cnt_r <= out_cnt_r + 1'b1;
    end
    assign pg_lost = tick && !s[I_FB_OUT] && (out_cnt_r == PG_OUT_CYCLES);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) pg_r <= 1'b0;
        else if (pg_lost || !en || th_r != TH_RUN) pg_r <= 1'b0;
        else if (qual_done) pg_r <= 1'b1;
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) startup_r <= 1'b0;
        else if (en_rise) startup_r <= 1'b1;
        else if (pg_r || !en) startup_r <= 1'b0;
    end
    assign power_ok = pg_r & ~pg_mask;

    // ********************************
    // interrupt status and pin
    // ********************************
    logic [NSRC-1:0] ev;
    logic pending_r;
    always_comb begin
        ev = '0;
        // the latch is still clear in the cycle that first sees the comparator
        ev[SRC_OV] = s[I_OV] & ~ov_fault_r;
        ev[SRC_SHDN] = en_fall;
        ev[SRC_THERM] = (th_r == TH_RUN) & s[I_THERM];
        ev[SRC_PG] = pg_lost & pg_r & ~pg_mask;
        ev[SRC_INOC] = tick & s[I_CLIM] & (cl_cnt_r == OC_LIMIT_CYCLES) & ~inner_oc_r;
        ev[SRC_OUTOC] = trip_any & en_settled_r & ~outer_trip_r;
        ev[SRC_FALL] = s[I_FALL] & ~s_q[I_FALL];
    end

    // a new event in the read cycle survives the clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) stat_r <= '0;
        else stat_r <= (stat_rd ? '0 : stat_r) | ev;
    end
    assign stat_b = {1'b0, startup_r, pg_r, outer_trip_r, inner_oc_r,
                     (th_r != TH_RUN), ov_fault_r, en};

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) pending_r <= 1'b0;
        else pending_r <= (|(stat_r & ~mask_r[NSRC-1:0])) | startup_r |
                          (ctl_r[CTL_PG_SHOW] & ~pg_r & ~pg_mask);
    end
    // open drain: the pin is released to its high active level while pending
    assign irq_pin_oe = ~pending_r;

    // ********************************
    // checks
    // ********************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    ov_latch_set_a: assert property (s[I_OV] |=> ov_fault_r)
        else $error("over-voltage not latched");
    ov_latch_hold_a: assert property (ov_fault_r |=> ov_fault_r)
        else $error("over-voltage fault cleared without reset");
    flag_gate_a: assert property (!en |=> ##1 !outer_overcurrent_flag)
        else $error("outer flag high while enable low");
    therm_off_a: assert property ($rose(s[I_THERM]) |-> ##[1:3] power_switches_off)
        else $error("switches not off on thermal trip");
    stat_set_a: assert property (|ev |=> ((stat_r & $past(ev)) == $past(ev)))
        else $error("status bit not set by event");
    mask_block_a: assert property ((mask_r[NSRC-1:0] == '1) && !startup_r &&
        !ctl_r[CTL_PG_SHOW] |=> irq_pin_oe)
        else $error("masked source drove the pin");
    pend_drive_a: assert property ((|(stat_r & ~mask_r[NSRC-1:0])) |=> !irq_pin_oe)
        else $error("pending request left the pin idle");
    pg_qual_a: assert property ($rose(pg_r) |-> $past(qual_done))
        else $error("power good without qualification");
    pg_drop_a: assert property (pg_lost |=> !pg_r)
        else $error("power good kept outside outer window");
    inoc_latch_a: assert property (en && tick && s[I_CLIM] &&
        cl_cnt_r == OC_LIMIT_CYCLES |=> inner_oc_r)
        else $error("inner overcurrent not latched");
    bulk_write_a: assert property (bus_we && bus_addr == REG_OUT |=>
        bulk_cap_switch_ctl == $past(bus_wdata[OUT_BULK]))
        else $error("bulk control did not follow write");
endmodule
`default_nettype wire

// ===== src/pmirq_pkg.sv
/*
 * Constants shared by the protection monitor and interrupt block: register
 * offsets and fields, source bit positions, synchroniser lane map, timing.
 * Assumes a 200 MHz core clock and an external serial protocol engine.
 */
package pmirq_pkg;

    // ********************************
    // bus and register map
    // ********************************
    localparam logic [6:0] DEV_ADDR = 7'h77;
    localparam logic [7:0] REG_MASK = 8'h09;
    localparam logic [7:0] REG_CTL = 8'h0A;
    localparam logic [7:0] REG_OUT = 8'h0B;
    localparam logic [7:0] REG_ADC = 8'h0C;
    localparam logic [7:0] REG_STAT_A = 8'h14;
    localparam logic [7:0] REG_STAT_B = 8'h15;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] OUT_RST = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // control register fields
    localparam int CTL_THR_A_LSB = 0;
    localparam int CTL_THR_B_LSB = 2;
    localparam int CTL_CMP_MASK_A = 4;
    localparam int CTL_CMP_MASK_B = 5;
    localparam int CTL_RESTART = 6;
    localparam int CTL_PG_SHOW = 7;
    // output register fields
    localparam int OUT_BULK = 0;
    localparam int OUT_PASS = 1;
    localparam int OUT_ADC_LSB = 2;
    localparam int OUT_PG_MASK = 4;

    // comparator threshold codes and their levels in mV
    localparam logic [1:0] THR_CODE_LOW = 2'h0;
    localparam int THR_MV_0 = 250;
    localparam int THR_MV_1 = 750;
    localparam int THR_MV_2 = 1500;
    localparam int THR_MV_3 = 2500;

    // converter input select codes, span and step
    localparam logic [1:0] ADC_SEL_FEEDBACK = 2'h0;
    localparam logic [1:0] ADC_SEL_SUPPLY = 2'h1;
    localparam logic [1:0] ADC_SEL_MON_B = 2'h2;
    localparam logic [1:0] ADC_SEL_MON_A = 2'h3;
    localparam int ADC_FULL_MV = 2550;
    localparam int ADC_STEP_MV = 20;
    localparam int ADC_SUPPLY_DIV = 10;
    localparam int ADC_W = 7;

    // ********************************
    // interrupt sources
    // ********************************
    localparam int NSRC = 7;
    localparam int SRC_OV = 0;
    localparam int SRC_SHDN = 1;
    localparam int SRC_THERM = 2;
    localparam int SRC_PG = 3;
    localparam int SRC_INOC = 4;
    localparam int SRC_OUTOC = 5;
    localparam int SRC_FALL = 6;

    // ********************************
    // synchroniser lanes
    // ********************************
    localparam int SYN_W = 11;
    localparam int I_CMP_A = 0;
    localparam int I_CMP_B = 1;
    localparam int I_EN = 2;
    localparam int I_OV = 3;
    localparam int I_THERM = 4;
    localparam int I_FB_IN = 5;
    localparam int I_FB_OUT = 6;
    localparam int I_CLIM = 7;
    localparam int I_SW = 8;
    localparam int I_FALL = 9;
    localparam int I_ADC = 10;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_MHZ = 200;
    localparam int PG_QUAL_US = 3300;
    localparam int PG_QUAL_CYC = PG_QUAL_US * CLK_MHZ;
    localparam int EN_SETTLE_US = 10;
    localparam int EN_SETTLE_CYC = EN_SETTLE_US * CLK_MHZ;
    localparam int EN_CNT_W = 12;
    localparam logic [2:0] OC_LIMIT_CYCLES = 3'h4;
    localparam logic [1:0] PG_OUT_CYCLES = 2'h1;

    typedef enum logic [1:0] {
        TH_RUN = 2'b00,
        TH_TRIP = 2'b01,
        TH_DISCH = 2'b10
    } pmirq_therm_e;

endpackage

// ===== src/pmirq_sync_if.sv
/*
 * Carrier between the top and its input synchroniser: raw pin levels in,
 * clean core-clock levels out.
 * Assumes the top drives raw and the synchroniser drives clean.
 */
`timescale 1ns/1ps
`default_nettype none
interface pmirq_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport syncer(input raw, output clean);
    modport user(output raw, input clean);
endinterface
`default_nettype wire

// ===== src/pmirq_sync.sv
/*
 * Two-stage synchroniser, one lane per asynchronous input.
 * Assumes each input is a level held far longer than two clock periods.
 */
`timescale 1ns/1ps
`default_nettype none
module pmirq_sync #(parameter int W = 1) (
    input wire logic ref_clk,
    input wire logic arst_n,
    pmirq_sync_if.syncer sif
);
    for (genvar i = 0; i < W; i++) begin : g_lane
        logic meta_r;
        logic hold_r;
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_r <= 1'b0;
                hold_r <= 1'b0;
            end else begin
                meta_r <= sif.raw[i];
                hold_r <= meta_r;
            end
        end
        assign sif.clean[i] = hold_r;
    end
endmodule
`default_nettype wire

// ===== src/pmirq_qual_timer.sv
/*
 * Qualification timer: done rises after run has held for CYCLES clocks in a
 * row and stays while run holds; any drop of run restarts the count.
 * Assumes run is already synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pmirq_qual_timer #(parameter int unsigned CYCLES = 1) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic run,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else if (!run) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else if (!done) begin
            cnt_r <= cnt_r + 1'b1;
            done <= (cnt_r == LAST);
        end
    end
endmodule
`default_nettype wire

// ===== verification/pmirq_host.sv
/*
 * Host-side bus master model for the protection monitor bench.
 * Assumes the block takes a one-cycle request and acks one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module pmirq_host (
    input wire logic ref_clk,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_ack,
    output logic bus_sel,
    output logic [6:0] bus_dev_addr,
    output logic bus_wr,
    output logic bus_rd,
    output logic [7:0] bus_addr,
    output logic [7:0] bus_wdata
);
    initial begin
        bus_sel = 1'b0;
        bus_dev_addr = 7'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
    end
    task automatic xfer(input logic [6:0] dev, input logic wr, input logic [7:0] a,
            input logic [7:0] wd, output logic [7:0] rd, output logic ack);
        @(posedge ref_clk);
        bus_sel <= 1'b1;
        bus_dev_addr <= dev;
        bus_wr <= wr;
        bus_rd <= !wr;
        bus_addr <= a;
        bus_wdata <= wd;
        @(posedge ref_clk);
        // released lines carry no stale value
        bus_sel <= 1'b0;
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~wd;
        // the answer stands through the cycle after the taken edge
        @(posedge ref_clk);
        rd = bus_rdata;
        ack = bus_ack;
    endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
/*
 * Self-checking bench for the protection monitor and interrupt block.
 * Assumes the host model as bus master and a shortened qualification time.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmirq_pkg::*;
    logic ref_clk, arst_n, ack, en, ov, th, fbw, done, sw, clim;
    logic [6:0] dev, adat;
    logic wr, rd, sel, bsw, pdo, poe, ipo, ioe, flag, susp, swo, dis, pok;
    logic [7:0] ad, wd, rdat, v;
    logic [1:0] ta, tb, ms;
    int err_total = 0, total_checks = 0, cyc = 0;
    pmirq_host host (.ref_clk(ref_clk), .bus_rdata(rdat), .bus_ack(ack), .bus_sel(sel),
        .bus_dev_addr(dev), .bus_wr(wr), .bus_rd(rd), .bus_addr(ad), .bus_wdata(wd));
    pmirq_top #(.PG_QUAL_CYCLES(50)) uut (.ref_clk(ref_clk), .arst_n(arst_n),
        .bus_sel(sel), .bus_dev_addr(dev), .bus_wr(wr), .bus_rd(rd), .bus_addr(ad),
        .bus_wdata(wd), .bus_rdata(rdat), .bus_ack(ack), .cmp_trip_a(1'b0),
        .cmp_trip_b(1'b0), .chip_en(en), .ov_cmp(ov), .thermal_trip(th),
        .fb_in_inner(fbw), .fb_in_outer(fbw), .cycle_limit(clim), .sw_cycle(sw),
        .falling_output_cmp(1'b0), .adc_done(done), .adc_data(adat),
        .cmp_threshold_sel_a(ta), .cmp_threshold_sel_b(tb), .outer_overcurrent_flag(flag),
        .converter_suspend(susp), .power_switches_off(swo), .discharge_req(dis),
        .power_ok(pok), .adc_mux_sel(ms), .bulk_cap_switch_ctl(bsw),
        .pass_switch_drive_out(pdo), .pass_switch_drive_oe(poe), .irq_pin_out(ipo),
        .irq_pin_oe(ioe));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // read with a field mask, expecting an ack
    task automatic rreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic k;
        host.xfer(DEV_ADDR, 1'b0, a, 8'h00, v, k);
        check({7'h00, k}, 8'h01);
        check(v & m, e);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic k;
        host.xfer(DEV_ADDR, 1'b1, a, d, v, k);
    endtask
    task automatic t_regs();
        logic k;
        rreg(REG_MASK, 8'hFF, MASK_RST);
        rreg(REG_CTL, 8'hFF, CTL_RST);
        check({4'h0, ta, tb}, 8'h00);
        check({6'h00, bsw, poe}, 8'h00);
        host.xfer(7'h76, 1'b0, REG_MASK, 8'h00, v, k);
        check({7'h00, k}, 8'h00);
        rreg(8'h30, 8'hFF, 8'h00);
        wreg(REG_CTL, 8'h0E);
        check({4'h0, ta, tb}, 8'h0B);
        check({4'h0, flag, susp, pdo, ipo}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wreg(REG_OUT, 8'h03 | 8'(i << 2));
            check({4'h0, ms, bsw, poe}, 8'(i << 2) | 8'h03);
        end
        $display("regs done");
    endtask
    task automatic t_pg();
        en <= 1'b1;
        fbw <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check({6'h00, ioe, pok}, 8'h00);
        repeat (60) @(posedge ref_clk);
        check({7'h00, pok}, 8'h01);
        $display("power good done");
    endtask
    // whole switching cycles; the block counts the rising edges
    task automatic sw_ticks(input int n);
        repeat (n) begin
            sw <= 1'b1;
            repeat (3) @(posedge ref_clk);
            sw <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask
    task automatic t_loss();
        fbw <= 1'b0;
        sw_ticks(1);
        check({7'h00, pok}, 8'h01);
        sw_ticks(1);
        check({7'h00, pok}, 8'h00);
        rreg(REG_STAT_A, 8'h08, 8'h08);
        fbw <= 1'b1;
        $display("power good loss done");
    endtask
    task automatic t_inoc();
        clim <= 1'b1;
        sw_ticks(4);
        rreg(REG_STAT_B, 8'h08, 8'h00);
        sw_ticks(1);
        rreg(REG_STAT_B, 8'h08, 8'h08);
        rreg(REG_STAT_A, 8'h10, 8'h10);
        clim <= 1'b0;
        $display("inner overcurrent done");
    endtask
    task automatic t_therm();
        th <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check({6'h00, swo, ioe}, 8'h02);
        wreg(REG_MASK, 8'h7F);
        repeat (8) @(posedge ref_clk);
        check({7'h00, ioe}, 8'h01);
        rreg(REG_STAT_A, 8'h04, 8'h04);
        rreg(REG_STAT_A, 8'hFF, 8'h00);
        th <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check({7'h00, dis}, 8'h01);
        wreg(REG_MASK, 8'h00);
        $display("thermal done");
    endtask
    task automatic t_ov();
        en <= 1'b0;
        ov <= 1'b1;
        repeat (8) @(posedge ref_clk);
        ov <= 1'b0;
        en <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check({7'h00, swo}, 8'h01);
        rreg(REG_STAT_B, 8'h02, 8'h02);
        $display("overvoltage done");
    endtask
    task automatic t_adc();
        adat <= 7'h5A;
        done <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rreg(REG_ADC, 8'hFF, 8'h5A);
        $display("converter done");
    endtask
    // the longest run is well below this many cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        arst_n = 1'b0;
        {en, ov, th, fbw, done, sw, clim} = 7'h00;
        adat = 7'h00;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_regs();
        t_pg();
        t_loss();
        t_therm();
        t_ov();
        t_inoc();
        t_adc();
        close_out();
    end
endmodule
`default_nettype wire
